// ===== logic/pbh_pkg.sv
package pbh_pkg;
  // ****************************************
  // phase-one timing, request and grant constants
  // ****************************************
  localparam int          PHASE_DIV_DEFAULT = 4;     // core cycles per phase-one period
  localparam int          CORE_PERIOD_NS    = 5;
  localparam int          GRANT_SETTLE_NS   = 9;     // grant settles after falling edge
  // longest time rounds down, never below one cycle
  localparam int          GRANT_SETTLE_CYC  = (GRANT_SETTLE_NS / CORE_PERIOD_NS) < 1 ? 1 :
                                              (GRANT_SETTLE_NS / CORE_PERIOD_NS);
  localparam int          REQ_MIN_PHASES    = 2;     // least request low time, phase periods
  localparam logic [1:0]  SYNC_RESET        = 2'h3;  // request idles high
  localparam logic        GRANT_RESET       = 1'b1;  // grant idles high (active low)

  typedef enum logic [2:0] {
    PBH_OWN     = 3'b000,
    PBH_QUIESCE = 3'b001,
    PBH_PARK    = 3'b010,
    PBH_FLOAT   = 3'b011,
    PBH_HELD    = 3'b100,
    PBH_RETURN  = 3'b101
  } pbh_state_t;
endpackage

// ===== logic/pbh_phase_gen.sv
`timescale 1ns/10ps
module pbh_phase_gen
  import pbh_pkg::*;
#(
  parameter int DIV = PHASE_DIV_DEFAULT
) (
  input  wire logic core_clk,  // core clock
  input  wire logic rst,       // sync reset, active high
  output logic      fall_en,   // phase-one falling edge pulse
  output logic      rise_en    // phase-one rising edge pulse
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_reg;

  // ****************************************
  // divider
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (cnt_reg == CW'(DIV - 1)) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  assign fall_en = (cnt_reg == CW'(DIV - 1));
  assign rise_en = (cnt_reg == CW'(DIV / 2 - 1));
endmodule

// ===== logic/pbh_hold_ctrl.sv
`timescale 1ns/10ps
// How it works
// - async request synchronised, sampled at falling edges
// - inhibit set forces exit from hold
// - inhibit set blocks any new hold
// - core bus access stalls while released
// - one write parked pending; second write stalls
// - grant low until one phase after release
// - grant changes only on falling edge
// - strobe driven high, then floated, re-enabled
// - read/write floated and re-enabled on falling edge
// - address floated and re-enabled on falling edge
// - data floated on rising edge
module pbh_hold_ctrl
  import pbh_pkg::*;
#(
  parameter int AW  = 24,
  parameter int DW  = 32,
  parameter int DIV = PHASE_DIV_DEFAULT
) (
  input  wire logic          core_clk,         // core clock
  input  wire logic          rst,              // sync reset, active high
  input  wire logic          release_req_n,    // bus-release request pin, active low
  input  wire logic          release_inhibit,  // inhibit bit from bus control register
  input  wire logic          cpu_req,          // core wants a primary-bus access
  input  wire logic          cpu_we,           // access is a write
  input  wire logic [AW-1:0] cpu_addr,         // access address
  input  wire logic [DW-1:0] cpu_wdata,        // write data
  output logic               cpu_stall,        // core must wait
  output logic               bus_busy,         // core access in flight this cycle
  output logic               release_grant_n,  // release grant pin, active low
  output logic               bus_strobe_o,     // strobe value, active low
  output logic               bus_strobe_oe,    // strobe driven
  output logic               bus_rw_o,         // read/write value, high is read
  output logic               bus_rw_oe,        // read/write driven
  output logic [AW-1:0]      bus_addr_o,       // address value
  output logic               bus_addr_oe,      // address driven
  output logic [DW-1:0]      bus_data_o,       // data value
  output logic               bus_data_oe,      // data driven
  output logic               pending_wr        // a write is parked
);
  logic            fall_en;
  logic            rise_en;
  logic [2:0]      sync_reg;
  logic            req_now;
  logic            held_req_reg;
  pbh_state_t      state_reg;
  logic            pend_reg;
  logic [AW-1:0]   pend_addr_reg;
  logic [DW-1:0]   pend_data_reg;
  logic            released;
  logic            grant_reg;
  logic            strobe_reg;
  logic            strobe_oe_reg;
  logic            ctrl_oe_reg;
  logic            data_oe_reg;
  logic            core_go;
  logic            issue_pend;
  logic [AW-1:0]   addr_reg;
  logic [DW-1:0]   data_reg;
  logic            rw_reg;

  pbh_phase_gen #(
    .DIV     (DIV)
  ) u_phase (
    .core_clk(core_clk),
    .rst     (rst),
    .fall_en (fall_en),
    .rise_en (rise_en)
  );

  // ****************************************
  // request synchroniser
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_reg <= {1'b1, SYNC_RESET};
    end else begin
      sync_reg <= {sync_reg[1:0], release_req_n};
    end
  end

  // stage 1 and 2 agree before the level counts; late setup costs a phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      held_req_reg <= 1'b0;
    end else if (sync_reg[1] == sync_reg[2]) begin
      held_req_reg <= ~sync_reg[2];
    end
  end
  assign req_now = held_req_reg;

  // ****************************************
  // hold sequencer, steps on falling edges
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= PBH_OWN;
    end else if (fall_en) begin
      unique case (state_reg)
        PBH_OWN: begin
          // inhibit refuses new holds; master holds req two phases
          if (req_now && !release_inhibit) begin
            state_reg <= PBH_QUIESCE;
          end
        end
        PBH_QUIESCE: begin
          if (release_inhibit || !req_now) begin
            state_reg <= PBH_OWN;
          end else if (!bus_busy) begin
            state_reg <= PBH_PARK;
          end
        end
        PBH_PARK:   state_reg <= PBH_FLOAT;
        PBH_FLOAT:  state_reg <= PBH_HELD;
        PBH_HELD: begin
          if (!req_now || release_inhibit) begin
            state_reg <= PBH_RETURN;
          end
        end
        PBH_RETURN: state_reg <= PBH_OWN;
        default:    state_reg <= PBH_OWN;
      endcase
    end
  end

  assign released = (state_reg != PBH_OWN) && (state_reg != PBH_QUIESCE);

  // ****************************************
  // core side: stall and pending write
  // ****************************************
  assign core_go    = cpu_req && !released && !pend_reg;
  assign issue_pend = pend_reg && !released;
  assign bus_busy   = core_go || issue_pend;
  // first write while released is parked; read or second write stalls
  assign cpu_stall  = cpu_req && (released || pend_reg) &&
                      !(cpu_we && !pend_reg);
  assign pending_wr = pend_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_reg      <= 1'b0;
      pend_addr_reg <= '0;
      pend_data_reg <= '0;
    end else if (cpu_req && cpu_we && released && !pend_reg) begin
      pend_reg      <= 1'b1;
      pend_addr_reg <= cpu_addr;
      pend_data_reg <= cpu_wdata;
    end else if (issue_pend) begin
      pend_reg      <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_reg <= '0;
      data_reg <= '0;
      rw_reg   <= 1'b1;
    end else if (issue_pend) begin
      addr_reg <= pend_addr_reg;
      data_reg <= pend_data_reg;
      rw_reg   <= 1'b0;
    end else if (core_go) begin
      addr_reg <= cpu_addr;
      data_reg <= cpu_wdata;
      rw_reg   <= ~cpu_we;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strobe_reg    <= 1'b1;
      strobe_oe_reg <= 1'b1;
      ctrl_oe_reg   <= 1'b1;
    end else if (fall_en) begin
      unique case (state_reg)
        PBH_PARK: begin
          strobe_reg    <= 1'b1;
          strobe_oe_reg <= 1'b1;
        end
        PBH_FLOAT: begin
          strobe_oe_reg <= 1'b0;
          ctrl_oe_reg   <= 1'b0;
        end
        PBH_RETURN: begin
          strobe_oe_reg <= 1'b1;
          ctrl_oe_reg   <= 1'b1;
        end
        default: strobe_reg <= ~(core_go || issue_pend);
      endcase
    end
  end

  // data lanes switch on the rising edge, not the falling one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_oe_reg <= 1'b0;
    end else if (rise_en) begin
      data_oe_reg <= !released && !rw_reg;
    end
  end

  // grant waits for every line to float; drops back at return
  always_ff @(posedge core_clk) begin
    if (rst) begin
      grant_reg <= GRANT_RESET;
    end else if (fall_en) begin
      grant_reg <= !(state_reg == PBH_HELD && req_now && !release_inhibit) &&
                   !(state_reg == PBH_FLOAT);
    end
  end

  assign release_grant_n = grant_reg;
  assign bus_strobe_o    = strobe_reg;
  assign bus_strobe_oe   = strobe_oe_reg;
  assign bus_rw_o        = rw_reg;
  assign bus_rw_oe       = ctrl_oe_reg;
  assign bus_addr_o      = addr_reg;
  assign bus_addr_oe     = ctrl_oe_reg;
  assign bus_data_o      = data_reg;
  assign bus_data_oe     = data_oe_reg;

  // ****************************************
  // checks
  // ****************************************
  property p_grant_on_edge;
    @(posedge core_clk) disable iff (rst)
      $changed(grant_reg) |-> $past(fall_en);
  endproperty
  a_grant_on_edge: assert property (p_grant_on_edge)
    else $error("grant moved off a phase-one falling edge");

  property p_grant_needs_float;
    @(posedge core_clk) disable iff (rst)
      !grant_reg |-> (!strobe_oe_reg && !ctrl_oe_reg && !data_oe_reg);
  endproperty
  a_grant_needs_float: assert property (p_grant_needs_float)
    else $error("grant low while bus still driven");

  property p_no_access_released;
    @(posedge core_clk) disable iff (rst)
      released |=> ($stable(addr_reg) && $stable(rw_reg));
  endproperty
  a_no_access_released: assert property (p_no_access_released)
    else $error("bus access while released");

  property p_second_write_stalls;
    @(posedge core_clk) disable iff (rst)
      (pend_reg && cpu_req && cpu_we && released) |-> cpu_stall;
  endproperty
  a_second_write_stalls: assert property (p_second_write_stalls)
    else $error("second write not stalled");

  property p_inhibit_no_entry;
    @(posedge core_clk) disable iff (rst)
      (state_reg == PBH_OWN && release_inhibit) |=> (state_reg == PBH_OWN);
  endproperty
  a_inhibit_no_entry: assert property (p_inhibit_no_entry)
    else $error("hold entered while inhibited");

  property p_inhibit_exit;
    @(posedge core_clk) disable iff (rst)
      (state_reg == PBH_HELD && release_inhibit && fall_en) |=> (state_reg == PBH_RETURN);
  endproperty
  a_inhibit_exit: assert property (p_inhibit_exit)
    else $error("hold kept while inhibited");

  property p_strobe_high_before_float;
    @(posedge core_clk) disable iff (rst)
      $fell(strobe_oe_reg) |-> $past(strobe_reg);
  endproperty
  a_strobe_high_before_float: assert property (p_strobe_high_before_float)
    else $error("strobe floated while low");

  property p_data_on_rise;
    @(posedge core_clk) disable iff (rst)
      $fell(data_oe_reg) |-> $past(rise_en);
  endproperty
  a_data_on_rise: assert property (p_data_on_rise)
    else $error("data float off rising edge");

  property p_ctrl_on_fall;
    @(posedge core_clk) disable iff (rst)
      $changed(ctrl_oe_reg) |-> $past(fall_en);
  endproperty
  a_ctrl_on_fall: assert property (p_ctrl_on_fall)
    else $error("rw/address enable moved off falling edge");
endmodule

// ===== tb/pbh_master_model.sv
`timescale 1ns/10ps
module pbh_master_model
  import pbh_pkg::*;
#(
  parameter int DIV = PHASE_DIV_DEFAULT
) (
  input  wire logic core_clk,      // core clock
  input  wire logic rst,           // sync reset, active high
  input  wire logic want,          // bench asks for the bus
  output logic      release_req_n  // request pin, active low
);
  // ****************************************
  // request pin, held low for a minimum span
  // ****************************************
  int low_cnt;

  initial begin
    release_req_n = 1'b1;
    low_cnt       = 0;
  end

  // a short pulse could be missed by the sampler, so never let go early
  always @(posedge core_clk) begin
    #1;
    if (rst) begin
      release_req_n = 1'b1;
      low_cnt       = 0;
    end else if (want) begin
      release_req_n = 1'b0;
      low_cnt       = low_cnt + 1;
    end else if (!release_req_n && low_cnt < REQ_MIN_PHASES * DIV) begin
      low_cnt = low_cnt + 1;
    end else begin
      release_req_n = 1'b1;
      low_cnt       = 0;
    end
  end
endmodule

// ===== tb/pbh_hold_ctrl_bench.sv
`timescale 1ns/10ps
module pbh_hold_ctrl_bench;
  import pbh_pkg::*;
  localparam int DIV = 4;
  logic core_clk, rst, want, req_n, inhibit, cpu_req, cpu_we, stall, busy, grant_n;
  logic strobe, strobe_oe, rw, rw_oe, addr_oe, data_oe, pend, fall_en, g_q, f_q;
  logic [23:0] addr, addr_o;
  logic [31:0] wdata, data_o;
  int err_total, n_compared, n;

  pbh_master_model #(.DIV(DIV)) pbh_master_model_i (.core_clk(core_clk), .rst(rst),
    .want(want), .release_req_n(req_n));
  int ph_cnt;
  // phase-one falls every DIV core cycles, counted from reset release
  always @(posedge core_clk) begin
    if (rst || ph_cnt == DIV - 1) ph_cnt <= 0;
    else ph_cnt <= ph_cnt + 1;
  end
  assign fall_en = (ph_cnt == DIV - 1);
  pbh_hold_ctrl #(.AW(24), .DW(32), .DIV(DIV)) pbh_hold_ctrl_i (.core_clk(core_clk),
    .rst(rst), .release_req_n(req_n), .release_inhibit(inhibit), .cpu_req(cpu_req),
    .cpu_we(cpu_we), .cpu_addr(addr), .cpu_wdata(wdata), .cpu_stall(stall),
    .bus_busy(busy), .release_grant_n(grant_n), .bus_strobe_o(strobe),
    .bus_strobe_oe(strobe_oe), .bus_rw_o(rw), .bus_rw_oe(rw_oe), .bus_addr_o(addr_o),
    .bus_addr_oe(addr_oe), .bus_data_o(data_o), .bus_data_oe(data_oe), .pending_wr(pend));

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask

  // bounded wait, n returns cycles taken
  task automatic wait_grant(input logic lvl);
    n = 0;
    while (grant_n !== lvl && n < 200) begin
      step(1);
      n++;
    end
    chk(grant_n, lvl);
  endtask

  task automatic wait_free();
    int k;
    k = 0;
    while (stall !== 1'b0 && k < 200) begin
      step(1);
      k++;
    end
    chk(stall, 1'b0);
  endtask

  // grant may move only on the edge that carries a phase-one fall
  always @(posedge core_clk) begin
    if (!rst && grant_n !== g_q) chk(f_q, 1'b1);
    g_q <= grant_n;
    f_q <= fall_en;
  end

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_hold();
    chk({grant_n, strobe_oe, rw_oe, addr_oe, data_oe, pend}, 32'h0000_003C);
    want = 1'b1;
    wait_grant(1'b0);
    chk({strobe_oe, rw_oe, addr_oe, data_oe}, 32'h0000_0000);
    chk(strobe, 1'b1);
    cpu_req = 1'b1;
    cpu_we  = 1'b0;
    addr    = 24'h00_1234;
    step(3);
    chk({stall, busy, addr_oe}, 32'h0000_0004);
    want = 1'b0;
    wait_grant(1'b1);
    chk((n >= 3) && (n <= 2 * DIV + 4), 1'b1);
    wait_free();
    chk({strobe_oe, rw_oe, addr_oe}, 32'h0000_0007);
    chk(busy, 1'b1);
    step(1);
    cpu_req = 1'b0;
    chk({8'h00, addr_o}, 32'h0000_1234);
    chk(rw, 1'b1);
    $display("test hold done");
  endtask

  task automatic t_pend();
    want = 1'b1;
    wait_grant(1'b0);
    cpu_req = 1'b1;
    cpu_we  = 1'b1;
    wdata   = 32'hA5A5_0F0F;
    chk(stall, 1'b0);
    step(1);
    cpu_req = 1'b0;
    step(1);
    chk({pend, data_oe}, 32'h0000_0002);
    cpu_req = 1'b1;
    wdata   = 32'h1111_2222;
    step(2);
    chk(stall, 1'b1);
    want = 1'b0;
    wait_grant(1'b1);
    wait_free();
    chk(data_o, 32'hA5A5_0F0F);
    chk(rw, 1'b0);
    step(1);
    cpu_req = 1'b0;
    chk(data_o, 32'h1111_2222);
    chk(data_oe, 1'b1);
    step(4 * DIV);
    chk({pend, grant_n}, 32'h0000_0001);
    $display("test pending done");
  endtask

  task automatic t_inhibit();
    inhibit = 1'b1;
    want    = 1'b1;
    n       = 0;
    repeat (60) begin
      step(1);
      if (grant_n !== 1'b1) n++;
    end
    chk(n, 0);
    inhibit = 1'b0;
    wait_grant(1'b0);
    inhibit = 1'b1;
    wait_grant(1'b1);
    chk(n <= 2 * DIV + 1, 1'b1);
    want = 1'b0;
    step(10 * DIV);
    inhibit = 1'b0;
    step(4 * DIV);
    chk(grant_n, 1'b1);
    $display("test inhibit done");
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    #(20000 * 5);
    err_total++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    want = 1'b0;
    inhibit = 1'b0;
    cpu_req = 1'b0;
    cpu_we = 1'b0;
    addr = 24'h00_0000;
    wdata = 32'h0000_0000;
    err_total = 0;
    n_compared = 0;
    g_q = 1'b1;
    f_q = 1'b0;
    step(4);
    rst = 1'b0;
    step(1);
    t_hold();
    t_pend();
    t_inhibit();
    finish_test();
  end
endmodule
